// File: design/sbse_exec.sv
// shift and byte store execute slice
// Operation
// - slli shifts left by immediate, zero fill
// - sra shifts by register low bits, sign fill
// - srai shifts right by immediate, sign fill
// - srl shifts by register low bits, zero fill
// - srli shifts right by immediate, zero fill
// - r-type fields decoded at fixed positions
// - byte address is base plus signed offset
// - store fields and opcodes 05 or 25
// - cached byte store may stay in cache
// - io store bypasses cache, always on bus
// - without cache, io store equals plain store
// - byte store reports six data exceptions
`timescale 1ns/1ns
module sbse_exec
	import sbse_pkg::*;
#(
	parameter bit HAS_DCACHE = 1'b1
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic srst_i,
	// instruction issue
	input wire logic issue_i,
	input wire logic [31:0] instr_i,
	input wire logic [31:0] first_source_i,
	input wire logic [31:0] second_source_i,
	output logic accept_o,
	// register file indices
	output logic [4:0] first_source_register_o,
	output logic [4:0] second_source_register_o,
	// destination write-back
	output logic wb_valid_o,
	output logic [4:0] destination_register_o,
	output logic [31:0] wb_data_o,
	// byte store to cache or bus
	output logic st_valid_o,
	output logic st_bypass_o,
	output logic [31:0] st_addr_o,
	output logic [7:0] st_data_o,
	input wire logic st_ready_i,
	// address checks from translation and protection
	input wire logic exc_super_i,
	input wire logic exc_misalign_i,
	input wire logic exc_perm_wr_i,
	input wire logic exc_fast_miss_i,
	input wire logic exc_double_miss_i,
	input wire logic exc_region_i,
	output logic exc_valid_o,
	output logic [5:0] exc_cause_o,
	// instruction not handled here
	output logic unsupported_o
);
	typedef struct packed {
		sbse_state_t state;
		logic wb_valid;
		logic [4:0] dest;
		logic [31:0] wb_data;
		logic st_valid;
		logic st_bypass;
		logic [31:0] st_addr;
		logic [7:0] st_data;
		logic exc_valid;
		logic [5:0] exc_cause;
	} sbse_state_reg_t;

	sbse_state_reg_t r;
	sbse_state_reg_t next_r;
	sbse_shift_if sh ();

	logic [5:0] opcode;
	logic [5:0] xop;
	logic [4:0] shift_amount_field;
	logic [15:0] signed_offset_field;
	logic is_shift;
	logic is_store;
	logic [5:0] exc_vec;

	// field extraction
	assign opcode = instr_i[OP_HI:OP_LO];
	assign xop = instr_i[X_HI:X_LO];
	assign shift_amount_field = instr_i[SH_HI:SH_LO];
	assign signed_offset_field = instr_i[OFS_HI:OFS_LO];
	assign first_source_register_o = instr_i[A_HI:A_LO];
	assign second_source_register_o = instr_i[B_HI:B_LO];
	assign is_store = (opcode == OP_STB) || (opcode == OP_STBIO);
	assign is_shift = (opcode == OP_RTYPE) && ((xop == XOP_SLLI) || (xop == XOP_SRA)
		|| (xop == XOP_SRAI) || (xop == XOP_SRL) || (xop == XOP_SRLI));
	assign exc_vec = {exc_region_i, exc_double_miss_i, exc_fast_miss_i,
		exc_perm_wr_i, exc_misalign_i, exc_super_i};

	// register operands use only bits 4..0; immediates use the field
	always_comb begin
		sh.value = first_source_i;
		sh.amount = shift_amount_field;
		sh.kind = SBSE_SH_SLL;
		unique case (xop)
			XOP_SRA: begin
				sh.amount = second_source_i[4:0];
				sh.kind = SBSE_SH_SRA;
			end
			XOP_SRAI: sh.kind = SBSE_SH_SRA;
			XOP_SRL: begin
				sh.amount = second_source_i[4:0];
				sh.kind = SBSE_SH_SRL;
			end
			XOP_SRLI: sh.kind = SBSE_SH_SRL;
			default: sh.kind = SBSE_SH_SLL;
		endcase
	end

	sbse_shifter u_shifter (
		.sh(sh.shifter)
	);

	// a store waits in BUSY until taken, so new work is refused meanwhile
	assign accept_o = (r.state == SBSE_IDLE);

	always_comb begin
		next_r = r;
		next_r.wb_valid = 1'b0;
		next_r.exc_valid = 1'b0;
		if (r.state == SBSE_BUSY && st_ready_i) begin
			next_r.st_valid = 1'b0;
			next_r.state = SBSE_IDLE;
		end
		if (r.state == SBSE_IDLE && issue_i) begin
			if (is_shift) begin
				// full word written in one cycle, zero amount passes through
				next_r.wb_valid = 1'b1;
				next_r.dest = instr_i[C_HI:C_LO];
				next_r.wb_data = sh.result;
			end else if (is_store) begin
				if (|exc_vec) begin
					// a faulting store never reaches memory
					next_r.exc_valid = 1'b1;
					next_r.exc_cause = exc_vec;
				end else begin
					next_r.st_valid = 1'b1;
					next_r.st_addr = first_source_i + {{16{signed_offset_field[15]}}, signed_offset_field};
					next_r.st_data = second_source_i[7:0];
					// cached form may be held by the cache io form goes to bus
					next_r.st_bypass = HAS_DCACHE && (opcode == OP_STBIO);
					next_r.state = SBSE_BUSY;
				end
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			r <= '{state: SBSE_IDLE, wb_valid: 1'b0, dest: 5'h00, wb_data: RESET_WORD,
				st_valid: 1'b0, st_bypass: 1'b0, st_addr: RESET_WORD, st_data: 8'h00,
				exc_valid: 1'b0, exc_cause: 6'h00};
		end else begin
			r <= next_r;
		end
	end

	assign wb_valid_o = r.wb_valid;
	assign destination_register_o = r.dest;
	assign wb_data_o = r.wb_data;
	assign st_valid_o = r.st_valid;
	assign st_bypass_o = r.st_bypass;
	assign st_addr_o = r.st_addr;
	assign st_data_o = r.st_data;
	assign exc_valid_o = r.exc_valid;
	assign exc_cause_o = r.exc_cause;
	assign unsupported_o = issue_i && accept_o && !is_shift && !is_store;

	a_slli_result: assert property (@(posedge clock_i) disable iff (srst_i)
		accept_o && issue_i && opcode == OP_RTYPE && xop == XOP_SLLI
		|=> wb_valid_o && wb_data_o == ($past(first_source_i) << $past(shift_amount_field)))
		else $error("slli result wrong");
	a_sra_result: assert property (@(posedge clock_i) disable iff (srst_i)
		accept_o && issue_i && opcode == OP_RTYPE && xop == XOP_SRA
		|=> wb_data_o == $unsigned($signed($past(first_source_i)) >>> $past(second_source_i[4:0])))
		else $error("sra result wrong");
	a_srai_result: assert property (@(posedge clock_i) disable iff (srst_i)
		accept_o && issue_i && opcode == OP_RTYPE && xop == XOP_SRAI
		|=> wb_data_o == $unsigned($signed($past(first_source_i)) >>> $past(shift_amount_field)))
		else $error("srai result wrong");
	a_srl_result: assert property (@(posedge clock_i) disable iff (srst_i)
		accept_o && issue_i && opcode == OP_RTYPE && xop == XOP_SRL
		|=> wb_data_o == ($past(first_source_i) >> $past(second_source_i[4:0])))
		else $error("srl result wrong");
	a_srli_result: assert property (@(posedge clock_i) disable iff (srst_i)
		accept_o && issue_i && opcode == OP_RTYPE && xop == XOP_SRLI
		|=> wb_data_o == ($past(first_source_i) >> $past(shift_amount_field)))
		else $error("srli result wrong");
	a_dest_index: assert property (@(posedge clock_i) disable iff (srst_i)
		accept_o && issue_i && is_shift |=> destination_register_o == $past(instr_i[C_HI:C_LO]))
		else $error("destination index wrong");
	a_store_addr: assert property (@(posedge clock_i) disable iff (srst_i)
		accept_o && issue_i && is_store && exc_vec == 6'h00
		|=> st_valid_o && st_addr_o == $past(first_source_i) + {{16{$past(instr_i[21])}}, $past(instr_i[21:6])}
		&& st_data_o == $past(second_source_i[7:0]))
		else $error("store address or data wrong");
	a_store_op: assert property (@(posedge clock_i) disable iff (srst_i)
		$rose(st_valid_o) |-> $past(opcode) == OP_STB || $past(opcode) == OP_STBIO)
		else $error("store from wrong opcode");
	a_io_bypass: assert property (@(posedge clock_i) disable iff (srst_i)
		$rose(st_valid_o) |-> st_bypass_o == (HAS_DCACHE && $past(opcode) == OP_STBIO))
		else $error("bypass flag wrong");
	a_store_hold: assert property (@(posedge clock_i) disable iff (srst_i)
		st_valid_o && !st_ready_i |=> st_valid_o && $stable(st_addr_o))
		else $error("store dropped before taken");
	a_exc_blocks: assert property (@(posedge clock_i) disable iff (srst_i)
		accept_o && issue_i && is_store && exc_vec != 6'h00 |=> exc_valid_o && !st_valid_o)
		else $error("faulting store not trapped");
	a_zero_shift: assert property (@(posedge clock_i) disable iff (srst_i)
		accept_o && issue_i && is_shift && sh.amount == 5'h00 |=> wb_data_o == $past(first_source_i))
		else $error("zero shift changed source");
endmodule

// File: design/sbse_shifter.sv
// combinational 32-bit barrel shifter
`timescale 1ns/1ns
module sbse_shifter
	import sbse_pkg::*;
(
	sbse_shift_if.shifter sh
);
	always_comb begin
		unique case (sh.kind)
			SBSE_SH_SLL: sh.result = sh.value << sh.amount;
			SBSE_SH_SRA: sh.result = $unsigned($signed(sh.value) >>> sh.amount);
			default: sh.result = sh.value >> sh.amount;
		endcase
	end
endmodule

// File: shared/sbse_pkg.sv
// constants and types for the shift and byte store execute slice
package sbse_pkg;
	localparam logic [5:0] OP_RTYPE = 6'h3A;
	localparam logic [5:0] OP_STB = 6'h05;
	localparam logic [5:0] OP_STBIO = 6'h25;
	localparam logic [5:0] XOP_SLLI = 6'h12;
	localparam logic [5:0] XOP_SRA = 6'h3B;
	localparam logic [5:0] XOP_SRAI = 6'h3A;
	localparam logic [5:0] XOP_SRL = 6'h1B;
	localparam logic [5:0] XOP_SRLI = 6'h1A;
	localparam int A_HI = 31;
	localparam int A_LO = 27;
	localparam int B_HI = 26;
	localparam int B_LO = 22;
	localparam int C_HI = 21;
	localparam int C_LO = 17;
	localparam int X_HI = 16;
	localparam int X_LO = 11;
	localparam int SH_HI = 10;
	localparam int SH_LO = 6;
	localparam int OFS_HI = 21;
	localparam int OFS_LO = 6;
	localparam int OP_HI = 5;
	localparam int OP_LO = 0;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	typedef enum logic [2:0] {
		SBSE_SH_SLL = 3'h1,
		SBSE_SH_SRL = 3'h2,
		SBSE_SH_SRA = 3'h4
	} sbse_shift_t;
	typedef enum logic [1:0] {
		SBSE_IDLE = 2'h1,
		SBSE_BUSY = 2'h2
	} sbse_state_t;
endpackage

// File: shared/sbse_shift_if.sv
// request carrier between decoder and shifter
`timescale 1ns/1ns
interface sbse_shift_if;
	logic [31:0] value;
	logic [4:0] amount;
	sbse_pkg::sbse_shift_t kind;
	logic [31:0] result;
	modport requester (output value, output amount, output kind, input result);
	modport shifter (input value, input amount, input kind, output result);
endinterface

// File: test/sbse_mem_model.sv
// byte store sink for the data cache and bus
`timescale 1ns/1ns
module sbse_mem_model (
	// clock and reset
	input wire logic clock_i,
	input wire logic srst_i,
	// store request
	input wire logic st_valid_i,
	input wire logic st_bypass_i,
	input wire logic [31:0] st_addr_i,
	input wire logic [7:0] st_data_i,
	input wire logic [3:0] stall_i,
	output logic st_ready_o,
	// last store taken
	output logic [39:0] last_o,
	output logic last_bypass_o
);
	logic [3:0] wait_cnt;
	// stall first, so a slow far side is exercised
	assign st_ready_o = st_valid_i && (wait_cnt >= stall_i);
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			wait_cnt <= 4'h0;
			last_o <= 40'h0;
			last_bypass_o <= 1'b0;
		end else if (st_ready_o) begin
			wait_cnt <= 4'h0;
			last_o <= {st_addr_i, st_data_i};
			last_bypass_o <= st_bypass_i;
		end else if (st_valid_i) begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule

// File: test/tb.sv
// bench for the shift and byte store execute slice
`timescale 1ns/1ns
module tb;
	import sbse_pkg::*;
	logic clock_i = 1'b0;
	logic srst_i = 1'b1;
	logic issue_i = 1'b0;
	logic [31:0] instr_i = 32'h0;
	logic [31:0] src_a = 32'h0;
	logic [31:0] src_b = 32'h0;
	logic [5:0] exc_in = 6'h00;
	logic acc, wbv, stv, stby, strdy, excv, unsup, lby;
	logic [4:0] ra, rb, rc;
	logic [31:0] wbd, sta;
	logic [7:0] std;
	logic [5:0] cause;
	logic [39:0] last;
	logic nc_stv, nc_stby;
	logic [31:0] nc_sta;
	logic [7:0] nc_std;
	int num_errors = 0;
	int check_count = 0;
	always #50 clock_i = ~clock_i;
	sbse_exec u_dut (.clock_i(clock_i), .srst_i(srst_i), .issue_i(issue_i), .instr_i(instr_i),
		.first_source_i(src_a), .second_source_i(src_b), .accept_o(acc), .first_source_register_o(ra),
		.second_source_register_o(rb), .wb_valid_o(wbv), .destination_register_o(rc), .wb_data_o(wbd),
		.st_valid_o(stv), .st_bypass_o(stby), .st_addr_o(sta), .st_data_o(std), .st_ready_i(strdy),
		.exc_super_i(exc_in[0]), .exc_misalign_i(exc_in[1]), .exc_perm_wr_i(exc_in[2]),
		.exc_fast_miss_i(exc_in[3]), .exc_double_miss_i(exc_in[4]), .exc_region_i(exc_in[5]),
		.exc_valid_o(excv), .exc_cause_o(cause), .unsupported_o(unsup));
	sbse_mem_model u_mem (.clock_i(clock_i), .srst_i(srst_i), .st_valid_i(stv), .st_bypass_i(stby),
		.st_addr_i(sta), .st_data_i(std), .stall_i(4'h3), .st_ready_o(strdy), .last_o(last), .last_bypass_o(lby));
	// same stimulus without a cache: timing mirrors u_dut, so the shared ready is valid for it
	sbse_exec #(.HAS_DCACHE(1'b0)) u_dut_nc (.clock_i(clock_i), .srst_i(srst_i), .issue_i(issue_i),
		.instr_i(instr_i), .first_source_i(src_a), .second_source_i(src_b), .accept_o(),
		.first_source_register_o(), .second_source_register_o(), .wb_valid_o(), .destination_register_o(),
		.wb_data_o(), .st_valid_o(nc_stv), .st_bypass_o(nc_stby), .st_addr_o(nc_sta), .st_data_o(nc_std),
		.st_ready_i(strdy), .exc_super_i(exc_in[0]), .exc_misalign_i(exc_in[1]), .exc_perm_wr_i(exc_in[2]),
		.exc_fast_miss_i(exc_in[3]), .exc_double_miss_i(exc_in[4]), .exc_region_i(exc_in[5]),
		.exc_valid_o(), .exc_cause_o(), .unsupported_o());
	task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic report_and_stop();
		if (num_errors == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic issue(input logic [31:0] ins, input logic [31:0] a, input logic [31:0] b);
		@(negedge clock_i);
		instr_i = ins;
		src_a = a;
		src_b = b;
		issue_i = 1'b1;
		@(negedge clock_i);
		issue_i = 1'b0;
	endtask
	task automatic wait_idle();
		int n = 0;
		while (acc !== 1'b1) begin
			@(negedge clock_i);
			n++;
			if (n > 20) begin
				num_errors++;
				report_and_stop();
			end
		end
	endtask
	task automatic run_shifts();
		logic [5:0] xop [5] = '{XOP_SLLI, XOP_SRA, XOP_SRAI, XOP_SRL, XOP_SRLI};
		logic [4:0] amt [5] = '{5'h04, 5'h03, 5'h1F, 5'h03, 5'h00};
		logic [31:0] expv [5] = '{32'h7654_3210, 32'hF0EC_A864, 32'hFFFF_FFFF, 32'h10EC_A864, 32'h8765_4321};
		logic [31:0] a = 32'h8765_4321;
		logic rf;
		for (int i = 0; i < 5; i++) begin
			rf = (i == 1) || (i == 3);
			// upper operand bits set to prove they are ignored
			issue({5'h11, rf ? 5'h0A : 5'h00, 5'h1D, xop[i], rf ? 5'h00 : amt[i], OP_RTYPE}, a,
				rf ? {27'h7FFFFFF, amt[i]} : 32'h0);
			chk("src_index", {5'h11, rf ? 5'h0A : 5'h00}, {ra, rb});
			chk("wb_valid", 1, wbv);
			chk("wb_dest", 5'h1D, rc);
			chk("wb_data", expv[i], wbd);
			@(negedge clock_i);
			chk("wb_pulse", 0, wbv);
		end
	endtask
	task automatic run_stores();
		logic [5:0] ops [2] = '{OP_STB, OP_STBIO};
		for (int i = 0; i < 2; i++) begin
			issue({5'h03, 5'h07, 16'hFFFC, ops[i]}, 32'h0000_1000, 32'h1234_56A5);
			chk("st_valid", 1, stv);
			chk("st_addr", 32'h0000_0FFC, sta);
			chk("st_data", 8'hA5, std);
			chk("st_bypass", i, stby);
			chk("accept", 0, acc);
			chk("nc_flags", 2'h2, {nc_stv, nc_stby});
			chk("nc_store", {32'h0000_0FFC, 8'hA5}, {nc_sta, nc_std});
			wait_idle();
			chk("bus_store", {32'h0000_0FFC, 8'hA5}, last);
			chk("bus_bypass", i, lby);
		end
	endtask
	task automatic run_exceptions();
		for (int i = 0; i < 6; i++) begin
			exc_in = 6'h01 << i;
			issue({5'h03, 5'h07, 16'h0001, OP_STB}, 32'h0000_1000, 32'h0000_0011);
			exc_in = 6'h00;
			chk("exc_valid", 1, excv);
			chk("exc_cause", 6'h01 << i, cause);
			@(negedge clock_i);
			chk("exc_pulse", 0, excv);
			wait_idle();
		end
	endtask
	task automatic run_unsupported();
		@(negedge clock_i);
		instr_i = {26'h0, 6'h04};
		issue_i = 1'b1;
		#1;
		chk("unsupported", 1, unsup);
		@(negedge clock_i);
		issue_i = 1'b0;
		chk("no_result", 0, {wbv, stv, excv});
	endtask
	initial begin
		repeat (4) @(negedge clock_i);
		srst_i = 1'b0;
		chk("reset_accept", 1, acc);
		run_shifts();
		run_stores();
		run_exceptions();
		run_unsupported();
		report_and_stop();
	end
endmodule
